// [logic/dms_pkg.sv]
package dms_pkg;
	localparam logic [7:0] ADDR_ALT_POINTER = 8'hfc;
	localparam logic [7:0] ADDR_STACK_POINTER = 8'hfd;
	localparam logic [7:0] ADDR_PRIMARY_POINTER = 8'hfe;
	localparam logic [7:0] ADDR_SEGMENT_EXTENSION = 8'hff;
	localparam logic [7:0] ADDR_REG_FILE_BASE = 8'hf0;
	localparam logic [7:0] ADDR_HOLE_BASE = 8'h70;
	localparam logic [7:0] SP_RESET_128 = 8'h6f;
	localparam logic [7:0] SP_RESET_64 = 8'h2f;
	localparam logic [7:0] SEGMENT_RESET = 8'h00;
	localparam logic [14:0] PC_RESET = 15'h0000;
	localparam logic [14:0] PC_INT_VECTOR = 15'h00ff;
	localparam logic [7:0] ERASED_BYTE = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam int PC_HIGH_W = 7;
	localparam int PC_LOW_W = 8;
	localparam int SEG_MSB = 7;

	typedef enum logic [1:0]
	{
		DMS_MODE_DIRECT = 2'b00,
		DMS_MODE_PRIMARY = 2'b01,
		DMS_MODE_ALT = 2'b11,
		DMS_MODE_STACK = 2'b10
	} dms_mode_e;

	typedef enum logic [1:0]
	{
		DMS_POST_NONE = 2'b00,
		DMS_POST_INC = 2'b01,
		DMS_POST_DEC = 2'b10
	} dms_post_e;

	typedef enum logic [3:0]
	{
		DMS_OP_NONE = 4'h0,
		DMS_OP_READ = 4'h1,
		DMS_OP_WRITE = 4'h2,
		DMS_OP_BIT_SET = 4'h3,
		DMS_OP_BIT_CLR = 4'h4,
		DMS_OP_BIT_TEST = 4'h5,
		DMS_OP_DEC_SKIP = 4'h6,
		DMS_OP_LOAD_IMM = 4'h7
	} dms_op_e;

	typedef enum logic [2:0]
	{
		DMS_ALU_ADD = 3'h0,
		DMS_ALU_SUB = 3'h1,
		DMS_ALU_AND = 3'h2,
		DMS_ALU_OR = 3'h3,
		DMS_ALU_XOR = 3'h4,
		DMS_ALU_SHL = 3'h5,
		DMS_ALU_SHR = 3'h6
	} dms_alu_e;
endpackage : dms_pkg

// [logic/dms_alu.sv]
`timescale 1ns/10ps
module dms_alu
	import dms_pkg::*;
#(
	parameter int W = 8
)
(
	input wire dms_alu_e op_i,
	input wire logic [W-1:0] a_i,
	input wire logic [W-1:0] b_i,
	input wire logic carry_i,
	output logic [W-1:0] result_o,
	output logic carry_o
);
	logic [W:0] wide;

	// Pure combinational so the result lands in the same cycle
	always_comb
	begin
		wide = '0;
		unique case (op_i)
			DMS_ALU_ADD: wide = {1'b0, a_i} + {1'b0, b_i} + {{W{1'b0}}, carry_i};
			DMS_ALU_SUB: wide = {1'b0, a_i} - {1'b0, b_i} - {{W{1'b0}}, ~carry_i};
			DMS_ALU_AND: wide = {1'b0, a_i & b_i};
			DMS_ALU_OR: wide = {1'b0, a_i | b_i};
			DMS_ALU_XOR: wide = {1'b0, a_i ^ b_i};
			DMS_ALU_SHL: wide = {a_i, carry_i};
			DMS_ALU_SHR: wide = {a_i[0], carry_i, a_i[W-1:1]};
			default: wide = '0;
		endcase
		result_o = wide[W-1:0];
		carry_o = (op_i == DMS_ALU_SUB) ? ~wide[W] : wide[W];
	end
endmodule : dms_alu

// [logic/dms_core.sv]
`timescale 1ns/10ps
module dms_core
	import dms_pkg::*;
#(
	parameter bit RAM_128 = 1'b1,
	parameter int PC_W = 15
)
(
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	// Data access request from instruction execution
	input wire logic REQ_I,
	input wire dms_op_e OP_I,
	input wire dms_mode_e MODE_I,
	input wire dms_post_e POST_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic [2:0] BIT_I,
	// Data returned from RAM or I/O space
	input wire logic [7:0] MEM_RDATA_I,
	output logic [15:0] MEM_ADDR_O,
	output logic MEM_RD_O,
	output logic MEM_WR_O,
	output logic [7:0] MEM_WDATA_O,
	output logic [7:0] RDATA_O,
	output logic BIT_O,
	output logic SKIP_O,
	// Accumulator bit test
	input wire logic [7:0] ACC_I,
	input wire logic [2:0] ACC_BIT_I,
	output logic ACC_BIT_O,
	// Single-cycle ALU
	input wire dms_alu_e ALU_OP_I,
	input wire logic [7:0] ALU_B_I,
	input wire logic ALU_CARRY_I,
	output logic [7:0] ALU_RESULT_O,
	output logic ALU_CARRY_O,
	// Program counter control
	input wire logic PC_ADV_I,
	input wire logic PC_LOAD_I,
	input wire logic [14:0] PC_LOAD_VAL_I,
	input wire logic INT_TAKE_I,
	input wire logic [7:0] PROG_DATA_I,
	input wire logic PROG_VALID_I,
	output logic [14:0] PROG_ADDR_O,
	output logic [6:0] PC_HIGH_O,
	output logic [7:0] PC_LOW_O,
	output logic [7:0] PROG_BYTE_O
);
	// ****************************************
	// Register state
	// ****************************************
	logic [7:0] alt_pointer, next_alt_pointer;
	logic [7:0] stack_pointer, next_stack_pointer;
	logic [7:0] primary_pointer, next_primary_pointer;
	logic [7:0] segment_extension, next_segment_extension;
	logic [7:0] reg_file [0:11];
	logic [7:0] next_reg_file [0:11];
	logic [PC_W-1:0] program_counter, next_program_counter;
	logic [7:0] acc_q, next_acc_q;

	logic [7:0] eff;
	logic [15:0] full_addr;
	logic [7:0] cur_val;
	logic [7:0] new_val;
	logic is_write;
	logic is_read;
	logic [7:0] dec_val;

	function automatic logic is_reg_file(input logic [7:0] a);
		is_reg_file = (a[7:4] == ADDR_REG_FILE_BASE[7:4]) &&
			(a < ADDR_ALT_POINTER);
	endfunction : is_reg_file

	function automatic logic is_core_reg(input logic [7:0] a);
		is_core_reg = (a[7:4] == ADDR_REG_FILE_BASE[7:4]);
	endfunction : is_core_reg

	function automatic logic is_hole(input logic [7:0] a);
		is_hole = (a[7:4] == ADDR_HOLE_BASE[7:4]);
	endfunction : is_hole

	// ****************************************
	// Address formation
	// ****************************************
	always_comb
	begin
		unique case (MODE_I)
			DMS_MODE_DIRECT: eff = ADDR_I;
			DMS_MODE_PRIMARY: eff = primary_pointer;
			DMS_MODE_ALT: eff = alt_pointer;
			DMS_MODE_STACK: eff = stack_pointer;
		endcase
		if (eff[SEG_MSB])
			full_addr = {8'h00, eff};
		else if (MODE_I == DMS_MODE_STACK)
			full_addr = {SEGMENT_RESET, eff};
		else
			full_addr = {segment_extension, eff};
	end

	// ****************************************
	// Read value and modify
	// ****************************************
	always_comb
	begin
		cur_val = UNMAPPED_READ;
		if (full_addr[15:8] == 8'h00 && is_core_reg(eff))
		begin
			unique case (eff)
				ADDR_ALT_POINTER: cur_val = alt_pointer;
				ADDR_STACK_POINTER: cur_val = stack_pointer;
				ADDR_PRIMARY_POINTER: cur_val = primary_pointer;
				ADDR_SEGMENT_EXTENSION: cur_val = segment_extension;
				default: cur_val = reg_file[eff[3:0]];
			endcase
		end
		else if (!(full_addr[15:8] == 8'h00 && is_hole(eff)))
			cur_val = MEM_RDATA_I;
		// Hole reads in segment zero stay at a constant with no access issued
		dec_val = cur_val - 8'h01;
		new_val = cur_val;
		is_write = 1'b0;
		is_read = 1'b0;
		unique case (OP_I)
			DMS_OP_READ, DMS_OP_BIT_TEST:
				is_read = 1'b1;
			DMS_OP_WRITE, DMS_OP_LOAD_IMM:
			begin
				is_write = 1'b1;
				new_val = WDATA_I;
			end
			DMS_OP_BIT_SET:
			begin
				is_read = 1'b1;
				is_write = 1'b1;
				new_val = cur_val | (8'h01 << BIT_I);
			end
			DMS_OP_BIT_CLR:
			begin
				is_read = 1'b1;
				is_write = 1'b1;
				new_val = cur_val & ~(8'h01 << BIT_I);
			end
			DMS_OP_DEC_SKIP:
			begin
				is_read = 1'b1;
				is_write = 1'b1;
				new_val = dec_val;
			end
			default:
			begin
				is_read = 1'b0;
			end
		endcase
		is_write = is_write && REQ_I;
		is_read = is_read && REQ_I;
	end

	// Memory side; core registers, and the hole while in segment zero, never reach RAM
	always_comb
	begin
		MEM_ADDR_O = full_addr;
		MEM_WDATA_O = new_val;
		MEM_RD_O = is_read && !(full_addr[15:8] == 8'h00 &&
			(is_core_reg(eff) || is_hole(eff)));
		MEM_WR_O = is_write && !(full_addr[15:8] == 8'h00 &&
			(is_core_reg(eff) || is_hole(eff)));
	end

	// ****************************************
	// Core register next state
	// ****************************************
	always_comb
	begin
		next_alt_pointer = alt_pointer;
		next_stack_pointer = stack_pointer;
		next_primary_pointer = primary_pointer;
		next_segment_extension = segment_extension;
		for (int i = 0; i < 12; i++)
			next_reg_file[i] = reg_file[i];
		// Post-update first; an explicit write to the pointer below wins
		if (REQ_I && OP_I != DMS_OP_NONE)
		begin
			if (MODE_I == DMS_MODE_PRIMARY && POST_I == DMS_POST_INC)
				next_primary_pointer = primary_pointer + 8'h01;
			if (MODE_I == DMS_MODE_PRIMARY && POST_I == DMS_POST_DEC)
				next_primary_pointer = primary_pointer - 8'h01;
			if (MODE_I == DMS_MODE_ALT && POST_I == DMS_POST_INC)
				next_alt_pointer = alt_pointer + 8'h01;
			if (MODE_I == DMS_MODE_ALT && POST_I == DMS_POST_DEC)
				next_alt_pointer = alt_pointer - 8'h01;
		end
		if (is_write && full_addr[15:8] == 8'h00 && is_core_reg(eff))
		begin
			unique case (eff)
				ADDR_ALT_POINTER: next_alt_pointer = new_val;
				ADDR_STACK_POINTER: next_stack_pointer = new_val;
				ADDR_PRIMARY_POINTER: next_primary_pointer = new_val;
				ADDR_SEGMENT_EXTENSION: next_segment_extension = new_val;
				default: next_reg_file[eff[3:0]] = new_val;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			alt_pointer <= 8'h00;
			stack_pointer <= RAM_128 ? SP_RESET_128 : SP_RESET_64;
			primary_pointer <= 8'h00;
			segment_extension <= SEGMENT_RESET;
			for (int i = 0; i < 12; i++)
				reg_file[i] <= 8'h00;
		end
		else
		begin
			alt_pointer <= next_alt_pointer;
			stack_pointer <= next_stack_pointer;
			primary_pointer <= next_primary_pointer;
			segment_extension <= next_segment_extension;
			for (int i = 0; i < 12; i++)
				reg_file[i] <= next_reg_file[i];
		end
	end

	// ****************************************
	// Read results
	// ****************************************
	logic [7:0] next_rdata;
	logic next_bit;
	logic next_skip;
	always_comb
	begin
		next_rdata = RDATA_O;
		next_bit = BIT_O;
		next_skip = 1'b0;
		if (is_read)
		begin
			next_rdata = cur_val;
			next_bit = cur_val[BIT_I];
			next_skip = (OP_I == DMS_OP_DEC_SKIP) && (dec_val == 8'h00);
		end
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			RDATA_O <= 8'h00;
			BIT_O <= 1'b0;
			SKIP_O <= 1'b0;
		end
		else
		begin
			RDATA_O <= next_rdata;
			BIT_O <= next_bit;
			SKIP_O <= next_skip;
		end
	end

	// ****************************************
	// Accumulator bit test and ALU
	// ****************************************
	// Accumulator lives outside the data map, so it is sampled here only
	always_comb
		next_acc_q = ACC_I;

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
			acc_q <= 8'h00;
		else
			acc_q <= next_acc_q;
	end

	assign ACC_BIT_O = acc_q[ACC_BIT_I];

	dms_alu #(.W(8)) u_alu
	(
		.op_i(ALU_OP_I),
		.a_i(ACC_I),
		.b_i(ALU_B_I),
		.carry_i(ALU_CARRY_I),
		.result_o(ALU_RESULT_O),
		.carry_o(ALU_CARRY_O)
	);

	// ****************************************
	// Program counter
	// ****************************************
	always_comb
	begin
		next_program_counter = program_counter;
		if (INT_TAKE_I)
			next_program_counter = PC_INT_VECTOR;
		else if (PC_LOAD_I)
			next_program_counter = PC_LOAD_VAL_I;
		else if (PC_ADV_I)
			next_program_counter = program_counter + 15'h0001;
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
			program_counter <= PC_RESET;
		else
			program_counter <= next_program_counter;
	end

	assign PROG_ADDR_O = program_counter;
	assign PC_HIGH_O = program_counter[PC_W-1:PC_LOW_W];
	assign PC_LOW_O = program_counter[PC_LOW_W-1:0];
	assign PROG_BYTE_O = PROG_VALID_I ? PROG_DATA_I : ERASED_BYTE;
endmodule : dms_core

// [verif/dms_properties.sv]
`timescale 1ns/10ps
module dms_properties
	import dms_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic REQ_I,
	input wire dms_op_e OP_I,
	input wire dms_mode_e MODE_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic [15:0] MEM_ADDR_O,
	input wire logic MEM_RD_O,
	input wire logic MEM_WR_O,
	input wire logic [7:0] RDATA_O,
	input wire logic SKIP_O,
	input wire logic INT_TAKE_I,
	input wire logic [14:0] PROG_ADDR_O,
	input wire logic [6:0] PC_HIGH_O,
	input wire logic [7:0] PC_LOW_O,
	input wire logic PROG_VALID_I,
	input wire logic [7:0] PROG_BYTE_O
);
	// ****
	// Segment shadow
	// ****
	// Tracks direct DMS_OP_WRITE only; load-immediate and bit ops on the segment byte are not followed
	logic [7:0] seg;
	logic [7:0] next_seg;
	always_comb
	begin
		next_seg = seg;
		if (REQ_I && OP_I == DMS_OP_WRITE && MODE_I == DMS_MODE_DIRECT
			&& ADDR_I == ADDR_SEGMENT_EXTENSION)
			next_seg = WDATA_I;
	end
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
			seg <= SEGMENT_RESET;
		else
			seg <= next_seg;
	end
	// ****
	// Properties
	// ****
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_direct;
		REQ_I && OP_I != DMS_OP_NONE && MODE_I == DMS_MODE_DIRECT;
	endsequence
	sequence s_hole_read;
		s_direct ##0 (OP_I == DMS_OP_READ && seg == 8'h00
			&& ADDR_I[7:4] == 4'h7);
	endsequence
	a_upper_no_ext: assert property (s_direct ##0 (ADDR_I[7]
		&& ADDR_I < 8'hf0) |-> MEM_ADDR_O == {8'h00, ADDR_I})
		else $error("upper segment extended");
	a_lower_seg_prefix: assert property (s_direct ##0 (!ADDR_I[7]
		&& !(seg == 8'h00 && ADDR_I[6:4] == 3'h7))
		|-> MEM_ADDR_O == {seg, ADDR_I})
		else $error("segment prefix wrong");
	a_stack_base: assert property (REQ_I && OP_I != DMS_OP_NONE
		&& MODE_I == DMS_MODE_STACK |-> MEM_ADDR_O[15:8] == 8'h00)
		else $error("stack left segment zero");
	a_hole_quiet: assert property (s_hole_read |->
		!MEM_RD_O && !MEM_WR_O ##1 RDATA_O == UNMAPPED_READ)
		else $error("hole access reached memory");
	a_skip_single: assert property (SKIP_O |->
		$past(REQ_I && OP_I == DMS_OP_DEC_SKIP))
		else $error("skip without decrement request");
	a_int_vector: assert property (INT_TAKE_I |=>
		PROG_ADDR_O == PC_INT_VECTOR)
		else $error("interrupt vector wrong");
	a_pc_halves: assert property (PROG_ADDR_O == {PC_HIGH_O, PC_LOW_O})
		else $error("counter halves disagree");
	a_reset_start: assert property ($fell(RST_I) |->
		PROG_ADDR_O == PC_RESET)
		else $error("fetch not from zero");
	a_erased_zero: assert property (!PROG_VALID_I |->
		PROG_BYTE_O == ERASED_BYTE)
		else $error("erased byte not zero");
endmodule : dms_properties

bind dms_core dms_properties u_props (.*);

// [verif/dms_mem_model.sv]
`timescale 1ns/10ps
module dms_mem_model
(
	input wire logic clk_i,
	input wire logic [15:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:65535];
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = i[7:0] ^ 8'h3c;
	end
	// Unselected bus shows the inverse so a stale byte never passes
	assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
	always @(posedge clk_i)
		if (wr_i)
			mem[addr_i] <= wdata_i;
endmodule : dms_mem_model

// [verif/testbench.sv]
`timescale 1ns/10ps
module testbench
	import dms_pkg::*;
;
	logic CORE_CLK_I = 0, RST_I = 1, REQ_I = 0, PROG_VALID_I = 0;
	logic ALU_CARRY_I = 0, PC_ADV_I = 0, PC_LOAD_I = 0, INT_TAKE_I = 0;
	dms_op_e OP_I = DMS_OP_NONE;
	dms_mode_e MODE_I = DMS_MODE_DIRECT;
	dms_post_e POST_I = DMS_POST_NONE;
	dms_alu_e ALU_OP_I = DMS_ALU_ADD;
	logic [7:0] ADDR_I = 0, WDATA_I = 0, ACC_I = 0, ALU_B_I = 0;
	logic [7:0] PROG_DATA_I = 8'h5a, MEM_RDATA_I, MEM_WDATA_O, RDATA_O;
	logic [7:0] ALU_RESULT_O, PC_LOW_O, PROG_BYTE_O;
	logic [2:0] BIT_I = 0, ACC_BIT_I = 0;
	logic [14:0] PC_LOAD_VAL_I = 0, PROG_ADDR_O;
	logic [15:0] MEM_ADDR_O;
	logic [6:0] PC_HIGH_O;
	logic MEM_RD_O, MEM_WR_O, BIT_O, SKIP_O, ACC_BIT_O, ALU_CARRY_O;
	int failures = 0, checks_done = 0;

	dms_core dut (.*);
	dms_mem_model mem_model (.clk_i(CORE_CLK_I), .addr_i(MEM_ADDR_O),
		.rd_i(MEM_RD_O), .wr_i(MEM_WR_O), .wdata_i(MEM_WDATA_O),
		.rdata_o(MEM_RDATA_I));

	always #25 CORE_CLK_I = ~CORE_CLK_I;

	// ****
	// Helpers
	// ****
	task chk(string n, logic [15:0] e, logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			failures++;
		end
	endtask : chk
	task tick;
		@(posedge CORE_CLK_I);
		#1;
	endtask : tick
	task acc(dms_op_e op, dms_mode_e md, dms_post_e p, logic [7:0] a, d);
		REQ_I = 1;
		OP_I = op;
		MODE_I = md;
		POST_I = p;
		ADDR_I = a;
		WDATA_I = d;
		tick;
	endtask : acc
	// Requests stay up until the next call so no strobe toggles in one step
	task idle;
		REQ_I = 0;
		OP_I = DMS_OP_NONE;
	endtask : idle
	task rd(logic [7:0] a);
		acc(DMS_OP_READ, DMS_MODE_DIRECT, DMS_POST_NONE, a, 0);
	endtask : rd
	task wr(logic [7:0] a, d);
		acc(DMS_OP_WRITE, DMS_MODE_DIRECT, DMS_POST_NONE, a, d);
	endtask : wr
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	// ****
	// Scenarios
	// ****
	task t_reset;
		rd(ADDR_STACK_POINTER);
		chk("stack pointer", 8'h6f, RDATA_O);
		chk("program counter", 0, PROG_ADDR_O);
		$display("reset test done");
	endtask : t_reset
	task t_segment;
		wr(8'hff, 8'h03);
		rd(8'hff);
		chk("segment", 8'h03, RDATA_O);
		wr(8'h12, 8'ha5);
		chk("extended ram", 8'ha5, mem_model.mem[16'h0312]);
		wr(8'h85, 8'h5c);
		chk("upper ram", 8'h5c, mem_model.mem[16'h0085]);
		acc(DMS_OP_WRITE, DMS_MODE_STACK, DMS_POST_NONE, 0, 8'h77);
		chk("stack ram", 8'h77, mem_model.mem[16'h006f]);
		rd(8'hff);
		chk("segment kept", 8'h03, RDATA_O);
		wr(8'hff, 8'h00);
		$display("segment test done");
	endtask : t_segment
	task t_pointers;
		wr(8'hfe, 8'h20);
		acc(DMS_OP_READ, DMS_MODE_PRIMARY, DMS_POST_INC, 0, 0);
		chk("via primary", 8'h20 ^ 8'h3c, RDATA_O);
		rd(8'hfe);
		chk("primary inc", 8'h21, RDATA_O);
		wr(8'hfc, 8'h30);
		acc(DMS_OP_WRITE, DMS_MODE_ALT, DMS_POST_DEC, 0, 8'h99);
		chk("via alt", 8'h99, mem_model.mem[16'h0030]);
		rd(8'hfc);
		chk("alt dec", 8'h2f, RDATA_O);
		$display("pointer test done");
	endtask : t_pointers
	task t_regs;
		acc(DMS_OP_LOAD_IMM, DMS_MODE_DIRECT, DMS_POST_NONE, 8'hf3, 8'h02);
		acc(DMS_OP_DEC_SKIP, DMS_MODE_DIRECT, DMS_POST_NONE, 8'hf3, 0);
		chk("no skip", 0, SKIP_O);
		acc(DMS_OP_DEC_SKIP, DMS_MODE_DIRECT, DMS_POST_NONE, 8'hf3, 0);
		chk("skip", 1, SKIP_O);
		idle;
		tick;
		chk("skip end", 0, SKIP_O);
		acc(DMS_OP_BIT_SET, DMS_MODE_DIRECT, DMS_POST_NONE, 8'hf5, 0);
		acc(DMS_OP_BIT_TEST, DMS_MODE_DIRECT, DMS_POST_NONE, 8'hf5, 0);
		chk("bit test", 1, BIT_O);
		acc(DMS_OP_BIT_CLR, DMS_MODE_DIRECT, DMS_POST_NONE, 8'hf5, 0);
		rd(8'hf5);
		chk("bit clear", 0, RDATA_O);
		acc(DMS_OP_BIT_SET, DMS_MODE_DIRECT, DMS_POST_NONE, 8'h40, 0);
		chk("ram bit set", 8'h7d, mem_model.mem[16'h0040]);
		wr(8'h75, 8'hee);
		chk("hole write", 8'h49, mem_model.mem[16'h0075]);
		rd(8'h75);
		chk("hole read", 0, RDATA_O);
		idle;
		$display("register test done");
	endtask : t_regs
	task t_core;
		PC_LOAD_VAL_I = 15'h7f01;
		PC_LOAD_I = 1;
		tick;
		PC_LOAD_I = 0;
		chk("pc high", 7'h7f, PC_HIGH_O);
		chk("pc low", 8'h01, PC_LOW_O);
		INT_TAKE_I = 1;
		tick;
		INT_TAKE_I = 0;
		chk("vector", 15'h00ff, PROG_ADDR_O);
		chk("erased", 0, PROG_BYTE_O);
		PROG_VALID_I = 1;
		#1;
		chk("programmed", 8'h5a, PROG_BYTE_O);
		PROG_VALID_I = 0;
		PC_ADV_I = 1;
		tick;
		PC_ADV_I = 0;
		chk("pc carry", 15'h0100, PROG_ADDR_O);
		chk("pc carry high", 7'h01, PC_HIGH_O);
		ACC_I = 8'h04;
		ACC_BIT_I = 2;
		tick;
		chk("acc bit", 1, ACC_BIT_O);
		ACC_I = 8'hf0;
		ALU_B_I = 8'h20;
		#1;
		chk("add", 9'h110, {ALU_CARRY_O, ALU_RESULT_O});
		ALU_OP_I = DMS_ALU_SUB;
		ALU_CARRY_I = 1;
		#1;
		chk("sub", 9'h1d0, {ALU_CARRY_O, ALU_RESULT_O});
		ALU_OP_I = DMS_ALU_SHL;
		#1;
		chk("shift", 9'h1e1, {ALU_CARRY_O, ALU_RESULT_O});
		ALU_OP_I = DMS_ALU_AND;
		#1;
		chk("and", 9'h020, {ALU_CARRY_O, ALU_RESULT_O});
		$display("core test done");
	endtask : t_core

	initial
	begin
		#100000;
		failures++;
		tally_and_finish;
	end
	initial
	begin
		repeat (5) @(posedge CORE_CLK_I);
		#1;
		RST_I = 0;
		t_reset;
		t_segment;
		t_pointers;
		t_regs;
		t_core;
		tally_and_finish;
	end
endmodule : testbench
